// >>> core/dshm_top.sv
// dac serial host port with control register, monitor mux and power-on reset
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
module dshm_top #(
  parameter int BROWNOUT_CYC = dshm_pkg::BROWNOUT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclk,
  input  wire logic        sync_n,
  input  wire logic        din,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  output logic             internal_reference_select,
  output logic             reference_value_select,
  output logic             monitor_output_en,
  output logic             monitor_output_oe,
  output logic      [5:0]  monitor_channel,
  output logic             por_busy
);
  // =====================================================
  // pin synchronisers; first stage read only by second
  logic [2:0] sclk_sy;
  logic [1:0] sync_sy;
  logic [1:0] din_sy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_sy <= 3'h0;
      sync_sy <= 2'h3;
      din_sy  <= 2'h0;
    end else if (clk_en) begin
      sclk_sy <= {sclk_sy[1:0], sclk};
      sync_sy <= {sync_sy[0], sync_n};
      din_sy  <= {din_sy[0], din};
    end
  end

  // =====================================================
  // power-on brownout hold
  logic [dshm_pkg::POR_CNT_W-1:0] por_q;
  wire por_done = (por_q == dshm_pkg::POR_CNT_W'(BROWNOUT_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_q <= '0;
    end else if (clk_en && !por_done) begin
      por_q <= por_q + 1'b1;
    end
  end

  // =====================================================
  // frame engine
  dshm_link_if lnk ();
  dshm_frame u_frame (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en & por_done),
    .sclk_s    (sclk_sy[1]),
    .sclk_prev (sclk_sy[2]),
    .sync_n_s  (sync_sy[1]),
    .din_s     (din_sy[1]),
    .lnk       (lnk)
  );

  // =====================================================
  // registers
  logic [31:0] ctrl_q;
  logic [5:0]  mon_q;
  logic [23:0] rxw_q;
  logic [23:0] txw_q;
  logic        rxnew_q;

  assign lnk.tx_word = txw_q;

  wire acc_w     = psel & penable;
  wire wr_w      = acc_w & pwrite;
  wire rd_w      = acc_w & ~pwrite;
  wire hit_ctrl  = (paddr == dshm_pkg::CTRL_ADDR);
  wire hit_mon   = (paddr == dshm_pkg::MON_ADDR);
  wire hit_stat  = (paddr == dshm_pkg::STATUS_ADDR);
  wire hit_rx    = (paddr == dshm_pkg::RXWORD_ADDR);
  wire hit_tx    = (paddr == dshm_pkg::TXWORD_ADDR);
  wire mapped_w  = hit_ctrl | hit_mon | hit_stat | hit_rx | hit_tx;
  wire mon_en_w  = ctrl_q[dshm_pkg::CTRL_MON_EN_BIT];
  wire [31:0] rd_mux =
      hit_ctrl ? ctrl_q :
      hit_mon  ? {26'h0, mon_q} :
      hit_stat ? {29'h0, rxnew_q, lnk.frame_active, ~por_done} :
      hit_rx   ? {8'h00, rxw_q} :
      hit_tx   ? {8'h00, txw_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= dshm_pkg::CTRL_RESET;
      mon_q   <= dshm_pkg::MON_SEL_RESET;
      rxw_q   <= 24'h000000;
      txw_q   <= 24'h000000;
      rxnew_q <= 1'b0;
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped_w;
      if (psel && !penable) begin
        prdata <= rd_mux;
      end
      if (wr_w && pready && hit_ctrl) begin
        ctrl_q <= pwdata;
      end
      // selection only accepted once monitoring is enabled
      if (wr_w && pready && hit_mon && mon_en_w) begin
        mon_q <= pwdata[5:0];
      end
      if (wr_w && pready && hit_tx) begin
        txw_q <= pwdata[23:0];
      end
      // a new word wins over the read clear
      if (lnk.rx_valid) begin
        rxw_q   <= lnk.rx_word;
        rxnew_q <= 1'b1;
      end else if (rd_w && pready && hit_rx) begin
        rxnew_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_data_out           <= 1'b0;
      serial_data_out_oe        <= 1'b0;
      internal_reference_select <= 1'b0;
      reference_value_select    <= 1'b0;
      monitor_output_en         <= 1'b0;
      monitor_output_oe         <= 1'b0;
      monitor_channel           <= dshm_pkg::MON_SEL_RESET;
      por_busy                  <= 1'b1;
    end else if (clk_en) begin
      serial_data_out           <= lnk.rb_bit;
      serial_data_out_oe        <= lnk.frame_active;
      internal_reference_select <= ctrl_q[dshm_pkg::CTRL_INT_REF_BIT];
      reference_value_select    <= ctrl_q[dshm_pkg::CTRL_REF_VAL_BIT];
      // last channel pin turns into the monitor pin
      monitor_output_en         <= mon_en_w;
      monitor_output_oe         <= mon_en_w & (mon_q != dshm_pkg::MON_SEL_HIZ);
      monitor_channel           <= mon_en_w ? mon_q : dshm_pkg::LAST_CHANNEL;
      por_busy                  <= ~por_done;
    end
  end
endmodule

// >>> shared/dshm_pkg.sv
// package of constants and types for the dac serial host monitor
package dshm_pkg;
  // =====================================================
  // register map (byte addresses)
  localparam logic [11:0] CTRL_ADDR      = 12'h000;
  localparam logic [11:0] MON_ADDR       = 12'h004;
  localparam logic [11:0] STATUS_ADDR    = 12'h008;
  localparam logic [11:0] RXWORD_ADDR    = 12'h00c;
  localparam logic [11:0] TXWORD_ADDR    = 12'h010;
  // =====================================================
  // control fields
  localparam int CTRL_MON_EN_BIT   = 0;
  localparam int CTRL_INT_REF_BIT  = 10;
  localparam int CTRL_REF_VAL_BIT  = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // =====================================================
  // monitor selection
  localparam int          MON_SEL_W     = 6;
  localparam logic [5:0]  MON_SEL_HIZ   = 6'h3f;
  localparam logic [5:0]  MON_SEL_RESET = 6'h3f;
  localparam logic [5:0]  LAST_CHANNEL  = 6'h27;
  // =====================================================
  // serial framing
  localparam int          WORD_W   = 24;
  localparam int          CNT_W    = 5;
  // =====================================================
  // power-on timing
  localparam int  CLK_MHZ        = 40;
  localparam int  BROWNOUT_MS    = 10;
  localparam int  BROWNOUT_CYC   = BROWNOUT_MS * 1000 * CLK_MHZ;
  localparam int  POR_CNT_W      = 19;
  typedef enum logic [1:0] {
    DSHM_ST_IDLE,
    DSHM_ST_SHIFT,
    DSHM_ST_DONE
  } dshm_state_e;
endpackage

// >>> shared/dshm_link_if.sv
// interface between the frame engine and the top module
`timescale 1ns/10ps
interface dshm_link_if;
  logic [23:0] rx_word;
  logic        rx_valid;
  logic [23:0] tx_word;
  logic        frame_active;
  logic        rb_bit;
  modport engine (output rx_word, output rx_valid, input tx_word, output frame_active,
                  output rb_bit);
  modport top    (input rx_word, input rx_valid, output tx_word, input frame_active,
                  input rb_bit);
endinterface

// >>> core/dshm_frame.sv
// serial frame engine: sampled clock edges, msb-first shift in and out
`timescale 1ns/10ps
module dshm_frame (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        sclk_s,
  input  wire logic        sclk_prev,
  input  wire logic        sync_n_s,
  input  wire logic        din_s,
  dshm_link_if.engine      lnk
);
  // =====================================================
  // edge decode on the synchronised link clock
  wire rise_w = sclk_s & ~sclk_prev;
  wire fall_w = ~sclk_s & sclk_prev;

  dshm_pkg::dshm_state_e state_q;
  logic [23:0] shin_q;
  logic [23:0] shout_q;
  logic [4:0]  cnt_q;
  logic        rb_q;
  logic        rxv_q;

  wire frame_w   = ~sync_n_s;
  wire word_full = (cnt_q == 5'(dshm_pkg::WORD_W - 1));

  assign lnk.rx_word      = shin_q;
  assign lnk.rx_valid     = rxv_q;
  assign lnk.frame_active = (state_q == dshm_pkg::DSHM_ST_SHIFT);
  assign lnk.rb_bit       = rb_q;

  // =====================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= dshm_pkg::DSHM_ST_IDLE;
      shin_q  <= 24'h000000;
      shout_q <= 24'h000000;
      cnt_q   <= 5'h00;
      rb_q    <= 1'b0;
      rxv_q   <= 1'b0;
    end else if (clk_en) begin
      rxv_q <= 1'b0;
      unique case (state_q)
        dshm_pkg::DSHM_ST_IDLE: begin
          // edges outside a frame are ignored; a falling sync starts a word
          if (frame_w) begin
            state_q <= dshm_pkg::DSHM_ST_SHIFT;
            cnt_q   <= 5'h00;
            shout_q <= lnk.tx_word;
            rb_q    <= lnk.tx_word[23];
          end
        end
        dshm_pkg::DSHM_ST_SHIFT: begin
          // host keeps sync low for the whole word; raising it abandons it
          if (!frame_w) begin
            state_q <= dshm_pkg::DSHM_ST_IDLE;
          end else begin
            if (rise_w) begin
              rb_q <= shout_q[23];
            end
            if (fall_w) begin
              // capture on falling edge, msb first; byte hosts build this from 3 bytes
              shin_q  <= {shin_q[22:0], din_s};
              shout_q <= {shout_q[22:0], 1'b0};
              cnt_q   <= cnt_q + 5'h01;
              if (word_full) begin
                state_q <= dshm_pkg::DSHM_ST_DONE;
                rxv_q   <= 1'b1;
              end
            end
          end
        end
        dshm_pkg::DSHM_ST_DONE: begin
          if (!frame_w) begin
            state_q <= dshm_pkg::DSHM_ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// >>> bench/dshm_checker.sv
// port assertions for the dac serial host port
`timescale 1ns/10ps
module dshm_checker #(
  parameter int BROWNOUT_CYC = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        sync_n,
  input wire logic        serial_data_out_oe,
  input wire logic        internal_reference_select,
  input wire logic        reference_value_select,
  input wire logic        monitor_output_en,
  input wire logic        monitor_output_oe,
  input wire logic [5:0]  monitor_channel,
  input wire logic        por_busy
);
  // ====
  // helpers
  logic acc;
  logic wr_ctrl;
  logic wr_mon;
  int   por_q;
  logic [5:0] sel_q;
  assign acc     = psel && penable && pready && pwrite;
  assign wr_ctrl = acc && (paddr == dshm_pkg::CTRL_ADDR);
  assign wr_mon  = acc && (paddr == dshm_pkg::MON_ADDR);
  // saturates so the counter never wraps in long runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_q <= 0;
    end else if (clk_en && por_q < BROWNOUT_CYC + 8) begin
      por_q <= por_q + 1;
    end
  end
  // mirror of the accepted selection; writes while disabled must not land
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= dshm_pkg::MON_SEL_RESET;
    end else if (clk_en && wr_mon && monitor_output_en) begin
      sel_q <= pwdata[5:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  // assertions
  // register lands one edge after the access, the pin one edge later
  a_ref_int: assert property (wr_ctrl |-> ##2
    internal_reference_select == $past(pwdata[dshm_pkg::CTRL_INT_REF_BIT], 2))
    else $error("internal reference select missed write");
  a_ref_val: assert property (wr_ctrl |-> ##2
    reference_value_select == $past(pwdata[dshm_pkg::CTRL_REF_VAL_BIT], 2))
    else $error("reference value select missed write");
  a_ref_hold: assert property (!wr_ctrl ##1 1'b1 |=> $stable(internal_reference_select))
    else $error("reference source changed without write");
  a_mon_en: assert property (wr_ctrl |-> ##2
    monitor_output_en == $past(pwdata[dshm_pkg::CTRL_MON_EN_BIT], 2))
    else $error("monitor enable missed write");
  a_mon_lock: assert property (monitor_output_en |-> monitor_channel == $past(sel_q))
    else $error("monitor routed while disabled");
  a_mon_hiz: assert property (monitor_channel == 6'h3f |-> !monitor_output_oe)
    else $error("monitor driven on channel 63");
  a_idle_quiet: assert property (sync_n [*8] |-> !serial_data_out_oe)
    else $error("readback driven outside frame");
  a_por_busy: assert property (por_q + 2 < BROWNOUT_CYC |-> por_busy)
    else $error("power-on hold ended early");
  a_por_done: assert property (por_q > BROWNOUT_CYC + 3 |-> !por_busy)
    else $error("power-on hold ended late");
endmodule
bind dshm_top dshm_checker #(.BROWNOUT_CYC(BROWNOUT_CYC)) u_chk (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .pwdata(pwdata), .sync_n(sync_n),
  .serial_data_out_oe(serial_data_out_oe),
  .internal_reference_select(internal_reference_select),
  .reference_value_select(reference_value_select), .monitor_output_en(monitor_output_en),
  .monitor_output_oe(monitor_output_oe), .monitor_channel(monitor_channel),
  .por_busy(por_busy));

// >>> bench/dshm_host_model.sv
// serial master model: clock idles low, data set on rise, sampled on fall
`timescale 1ns/10ps
module dshm_host_model (
  output logic      sclk,
  output logic      sync_n,
  output logic      din,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
  end
  // edges with the frame closed must be ignored by the device
  task automatic stray(input int n);
    repeat (n) begin
      #100 sclk = 1'b1;
      din = ~din;
      #100 sclk = 1'b0;
    end
  endtask
  // byte-wide host: eight falls per byte, pause between bytes
  task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
    sync_n = 1'b0;
    #100;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      din = tx[23-i];
      #100 sclk = 1'b0;
      rx = {rx[22:0], miso};
      #100;
      if (i % 8 == 7) #200;
    end
    sync_n = 1'b1;
    din = ~din;
    #200;
  endtask
endmodule

// >>> bench/dac_serial_host_monitor_tb_top.sv
// self-checking bench for the dac serial host port
`timescale 1ns/10ps
module dac_serial_host_monitor_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sclk, sync_n, din;
  logic        serial_data_out, serial_data_out_oe, internal_reference_select, por_busy;
  logic        reference_value_select, monitor_output_en, monitor_output_oe, err, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [5:0]  monitor_channel;
  logic [23:0] rx;
  int          miscompares, num_checks;
  dshm_top #(.BROWNOUT_CYC(20)) dut (.pclk, .presetn, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sclk, .sync_n, .din,
    .serial_data_out, .serial_data_out_oe, .internal_reference_select,
    .reference_value_select, .monitor_output_en, .monitor_output_oe, .monitor_channel,
    .por_busy);
  // a released line reads inverted, so a late output enable corrupts readback
  dshm_host_model host (.sclk, .sync_n, .din,
    .miso(serial_data_out_oe ? serial_data_out : ~serial_data_out));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ====
  // tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // pins follow their registers one edge after the commit
    repeat (2) @(posedge pclk);
    if (n >= 50) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // ====
  // sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    miscompares = 0;
    num_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 check("por_busy", por_busy, 1);
    // a low clock enable must freeze the power-on count too
    @(posedge pclk);
    clk_en <= 1'b0;
    repeat (30) @(posedge pclk);
    check("por_frozen", por_busy, 1);
    clk_en <= 1'b1;
    repeat (30) @(posedge pclk);
    apb(0, dshm_pkg::STATUS_ADDR, 0);
    check("status", q, 0);
    apb(0, dshm_pkg::CTRL_ADDR, 0);
    check("ctrl", q, 0);
    for (int i = 0; i < 4; i++) begin
      d = {19'h0, i[1], 1'b0, i[0], 10'h0};
      apb(1, dshm_pkg::CTRL_ADDR, d);
      apb(0, dshm_pkg::CTRL_ADDR, 0);
      check("ctrl", q, d);
      check("refs", {reference_value_select, internal_reference_select}, i[1:0]);
    end
    apb(1, dshm_pkg::MON_ADDR, 5);
    check("mon", {monitor_output_oe, monitor_channel}, 7'h27);
    apb(1, dshm_pkg::CTRL_ADDR, 1);
    apb(0, dshm_pkg::MON_ADDR, 0);
    check("mon_sel", q, dshm_pkg::MON_SEL_RESET);
    apb(1, dshm_pkg::MON_ADDR, 5);
    check("mon", {monitor_output_en, monitor_output_oe, monitor_channel}, 8'hc5);
    apb(1, dshm_pkg::MON_ADDR, 63);
    check("mon_oe", monitor_output_oe, 0);
    apb(0, 12'h020, 0);
    check("unmapped_err", err, 1);
    check("unmapped_rd", q, 0);
    apb(1, dshm_pkg::TXWORD_ADDR, 32'h00a5_c396);
    // link edges land midway between pclk edges so sampling is never a race
    #12.5;
    host.stray(4);
    host.xfer(24'h3c5ae1, 24, rx);
    check("readback", rx, 24'ha5c396);
    apb(0, dshm_pkg::STATUS_ADDR, 0);
    check("rxnew", q[2], 1);
    apb(0, dshm_pkg::RXWORD_ADDR, 0);
    check("rxword", q, 32'h003c_5ae1);
    #12.5;
    host.xfer(24'h123456, 16, rx);
    apb(0, dshm_pkg::STATUS_ADDR, 0);
    check("rxnew", q[2], 0);
    tally_and_finish();
  end
endmodule
